// *** analog_input_pkg.sv ***
package analog_input_pkg;

    localparam int CH_N = 4;
    localparam int CH_W = 2;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // Range codes.
    localparam int RANGE_N = 6;
    localparam int RANGE_W = 3;
    localparam logic [2:0] RANGE_BIP10 = 3'h0;
    localparam logic [2:0] RANGE_BIP5 = 3'h1;
    localparam logic [2:0] RANGE_UNI10 = 3'h2;
    localparam logic [2:0] RANGE_UNI5 = 3'h3;
    localparam logic [2:0] RANGE_UNI1_5 = 3'h4;
    localparam logic [2:0] RANGE_CUR4_20 = 3'h5;
    localparam logic [2:0] RANGE_MAX = 3'h5;
    localparam logic [2:0] RANGE_RST = 3'h0;

    // Per-range limits, indexed by range code.
    localparam logic signed [15:0] NOM_MIN [RANGE_N] = '{
        -16'sh2710, -16'sh2710, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000};
    localparam logic signed [15:0] NOM_MAX [RANGE_N] = '{
        16'sh2710, 16'sh2710, 16'sh2710, 16'sh2710, 16'sh2710, 16'sh2710};
    localparam logic signed [15:0] LO_DEF [RANGE_N] = '{
        -16'sh2AF8, -16'sh2AF8, -16'sh03E8, -16'sh03E8, -16'sh0320,
        -16'sh0320};
    localparam logic signed [15:0] HI_DEF [RANGE_N] = '{
        16'sh2AF8, 16'sh2AF8, 16'sh2AF8, 16'sh2AF8, 16'sh2A30, 16'sh2A30};
    localparam logic signed [15:0] LO_END [RANGE_N] = '{
        -16'sh2C88, -16'sh3A98, -16'sh0578, -16'sh1388, -16'sh0FA0,
        -16'sh0FA0};
    localparam logic signed [15:0] HI_END [RANGE_N] = '{
        16'sh2C88, 16'sh3A98, 16'sh2C88, 16'sh3A98, 16'sh36B0, 16'sh36B0};

    localparam logic signed [15:0] S16_MIN = -16'sh8000;
    localparam logic signed [15:0] S16_MAX = 16'sh7FFF;
    localparam logic signed [15:0] ALIGN_LIMIT = 16'sh05DC;
    localparam logic signed [15:0] BROKEN_LIMIT = -16'sh07D0;

    // Filter.
    localparam logic [2:0] K_MAX = 3'h6;
    localparam logic [2:0] K_RST = 3'h0;
    localparam int FILT_FRAC = 8;
    localparam int FILT_W = DATA_W + FILT_FRAC;

    // Register map: channel word address is {2'b00, channel, index}.
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_LO_THR = 4'h1;
    localparam logic [3:0] REG_HI_THR = 4'h2;
    localparam logic [3:0] REG_USER_LO = 4'h3;
    localparam logic [3:0] REG_USER_HI = 4'h4;
    localparam logic [3:0] REG_FILT_K = 4'h5;
    localparam logic [3:0] REG_ALIGN_OFS = 4'h6;
    localparam logic [3:0] REG_ALIGN_TGT = 4'h7;
    localparam logic [3:0] REG_VALUE = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam logic [7:0] REG_CTRL = 8'h40;
    localparam logic signed [15:0] USER_LO_RST = 16'sh0000;
    localparam logic signed [15:0] USER_HI_RST = 16'sh2710;

    localparam int CFG_IN_USE_BIT = 3;
    localparam int CFG_USER_BIT = 4;
    localparam int CTRL_FAST_BIT = 0;
    localparam int ST_UDF = 0;
    localparam int ST_OVF = 1;
    localparam int ST_LO_TOL = 2;
    localparam int ST_HI_TOL = 3;
    localparam int ST_BROKEN = 4;
    localparam int ST_ALIGNED = 5;
    localparam int ST_VALID = 6;

    // Acquisition timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_TIME_NS = 1300000;
    localparam int FIXED_CYCLE_NS = 6500000;
    localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int FIXED_SLOTS = FIXED_CYCLE_NS / SLOT_TIME_NS;
    localparam int TIMER_W = 18;
    localparam int SLOT_W = 3;

endpackage

// *** range_classifier.sv ***
`timescale 1ns/1ns
module range_classifier (
    // Measurement and limits.
    input wire logic signed [15:0] value,
    input wire logic signed [15:0] nom_min,
    input wire logic signed [15:0] nom_max,
    input wire logic signed [15:0] lo_thr,
    input wire logic signed [15:0] hi_thr,
    // Classification.
    output logic underflow,
    output logic overflow,
    output logic lo_tol,
    output logic hi_tol
);

    always_comb begin
        overflow = value > hi_thr;
        underflow = value < lo_thr;
        hi_tol = (value > nom_max) && !overflow;
        lo_tol = (value < nom_min) && !underflow;
    end

endmodule

// *** recursive_filter.sv ***
`timescale 1ns/1ns
module recursive_filter (
    // State and sample.
    input wire logic signed [23:0] state_in,
    input wire logic signed [15:0] sample,
    input wire logic [2:0] k,
    input wire logic prime,
    // Result.
    output logic signed [23:0] state_out,
    output logic signed [15:0] value
);

    logic signed [23:0] sample_ext;
    logic signed [24:0] diff;
    logic signed [24:0] step;
    logic signed [24:0] rounded;

    always_comb begin
        sample_ext = {sample, 8'h00};
        diff = 25'(sample_ext) - 25'(state_in);
        step = diff >>> (k + 3'h1);
        if (prime || k == 3'h0) begin
            state_out = sample_ext;
        end else begin
            state_out = 24'(25'(state_in) + step);
        end
        rounded = 25'(state_out) + 25'sh0000080;
        value = rounded[23:8];
    end

endmodule

// *** analog_input_conditioning.sv ***
`timescale 1ns/1ns
module analog_input_conditioning #(
    parameter int SLOT_CYCLES = analog_input_pkg::SLOT_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    // Converter.
    output logic acq_req,
    output logic [1:0] acq_chan,
    input wire logic samp_valid,
    input wire logic [1:0] samp_chan,
    input wire logic signed [15:0] samp_raw,
    // Channel status.
    output logic [3:0] over_range,
    output logic [3:0] under_range,
    output logic [3:0] broken_wire
);

    localparam int N = analog_input_pkg::CH_N;

    logic [2:0] range_reg [N];
    logic [N-1:0] in_use_reg;
    logic [N-1:0] user_reg;
    logic signed [15:0] lo_thr_reg [N];
    logic signed [15:0] hi_thr_reg [N];
    logic signed [15:0] user_lo_reg [N];
    logic signed [15:0] user_hi_reg [N];
    logic [2:0] k_reg [N];
    logic signed [15:0] ofs_reg [N];
    logic [N-1:0] aligned_reg;
    logic fast_reg;
    logic [N-1:0] prime_reg;
    logic signed [23:0] filt_reg [N];
    logic signed [15:0] value_reg [N];
    logic signed [15:0] corr_reg [N];
    logic signed [15:0] last_raw_reg [N];
    logic [4:0] status_reg [N];
    logic [N-1:0] valid_reg;
    logic [2:0] slot_reg;
    logic [17:0] tmr_reg;

    function automatic logic signed [15:0] clamp_s(
        input logic signed [39:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        logic signed [15:0] r;
        r = v[15:0];
        if (v < 40'(lo)) begin
            r = lo;
        end else if (v > 40'(hi)) begin
            r = hi;
        end
        return r;
    endfunction

    // Register decode.
    logic ch_hit;
    logic [1:0] wch;
    logic [3:0] widx;
    logic [2:0] wrng;
    logic [2:0] new_rng;
    logic cfg_wr;
    logic rng_change;
    logic k_wr_ok;

    always_comb begin
        ch_hit = addr[7:6] == 2'h0;
        wch = addr[5:4];
        widx = addr[3:0];
        wrng = range_reg[wch];
        new_rng = (wdata[2:0] > analog_input_pkg::RANGE_MAX) ?
            analog_input_pkg::RANGE_MAX : wdata[2:0];
        cfg_wr = wr_en && ch_hit && widx == analog_input_pkg::REG_CFG;
        rng_change = cfg_wr && new_rng != wrng;
        k_wr_ok = wr_en && ch_hit && widx == analog_input_pkg::REG_FILT_K
            && wdata <= 16'(analog_input_pkg::K_MAX);
    end

    // Sample path.
    logic [2:0] srng;
    logic signed [15:0] corr;
    logic signed [23:0] filt_next;
    logic signed [15:0] filt_val;
    logic udf;
    logic ovf;
    logic lo_tol;
    logic hi_tol;
    logic broken;
    logic signed [17:0] span_off;
    logic signed [16:0] user_span;
    logic signed [34:0] prod;
    logic signed [34:0] quot;
    logic signed [15:0] scaled;

    always_comb begin
        srng = range_reg[samp_chan];
        corr = clamp_s(40'(samp_raw) + 40'(ofs_reg[samp_chan]),
            analog_input_pkg::LO_END[srng], analog_input_pkg::HI_END[srng]);
        broken = (srng == analog_input_pkg::RANGE_UNI1_5 ||
            srng == analog_input_pkg::RANGE_CUR4_20) &&
            samp_raw < analog_input_pkg::BROKEN_LIMIT;
        span_off = 18'(filt_val) - 18'(analog_input_pkg::NOM_MIN[srng]);
        user_span = 17'(user_hi_reg[samp_chan]) -
            17'(user_lo_reg[samp_chan]);
        prod = 35'(span_off) * 35'(user_span);
        quot = prod / (35'(analog_input_pkg::NOM_MAX[srng]) -
            35'(analog_input_pkg::NOM_MIN[srng]));
        if (user_reg[samp_chan]) begin
            scaled = clamp_s(40'(quot) + 40'(user_lo_reg[samp_chan]),
                analog_input_pkg::S16_MIN, analog_input_pkg::S16_MAX);
        end else begin
            scaled = filt_val;
        end
    end

    recursive_filter u_filter (
        .state_in(filt_reg[samp_chan]),
        .sample(corr),
        .k(k_reg[samp_chan]),
        .prime(prime_reg[samp_chan]),
        .state_out(filt_next),
        .value(filt_val)
    );

    range_classifier u_classifier (
        .value(corr),
        .nom_min(analog_input_pkg::NOM_MIN[srng]),
        .nom_max(analog_input_pkg::NOM_MAX[srng]),
        .lo_thr(lo_thr_reg[samp_chan]),
        .hi_thr(hi_thr_reg[samp_chan]),
        .underflow(udf),
        .overflow(ovf),
        .lo_tol(lo_tol),
        .hi_tol(hi_tol)
    );

    // Channel configuration writes.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                range_reg[i] <= analog_input_pkg::RANGE_RST;
                lo_thr_reg[i] <= analog_input_pkg::LO_DEF[0];
                hi_thr_reg[i] <= analog_input_pkg::HI_DEF[0];
                user_lo_reg[i] <= analog_input_pkg::USER_LO_RST;
                user_hi_reg[i] <= analog_input_pkg::USER_HI_RST;
                k_reg[i] <= analog_input_pkg::K_RST;
            end
            in_use_reg <= '0;
            user_reg <= '0;
            fast_reg <= 1'b0;
        end else if (wr_en && ch_hit) begin
            case (widx)
                analog_input_pkg::REG_CFG: begin
                    range_reg[wch] <= new_rng;
                    in_use_reg[wch] <= wdata[analog_input_pkg::CFG_IN_USE_BIT];
                    user_reg[wch] <= wdata[analog_input_pkg::CFG_USER_BIT];
                    if (rng_change) begin
                        lo_thr_reg[wch] <= analog_input_pkg::LO_DEF[new_rng];
                        hi_thr_reg[wch] <= analog_input_pkg::HI_DEF[new_rng];
                    end
                end
                analog_input_pkg::REG_LO_THR: begin
                    // lower threshold clamped to its area
                    lo_thr_reg[wch] <= clamp_s(40'($signed(wdata)),
                        analog_input_pkg::LO_END[wrng],
                        analog_input_pkg::NOM_MIN[wrng]);
                end
                analog_input_pkg::REG_HI_THR: begin
                    hi_thr_reg[wch] <= clamp_s(40'($signed(wdata)),
                        analog_input_pkg::NOM_MAX[wrng],
                        analog_input_pkg::HI_END[wrng]);
                end
                analog_input_pkg::REG_USER_LO: begin
                    user_lo_reg[wch] <= wdata;
                end
                analog_input_pkg::REG_USER_HI: begin
                    user_hi_reg[wch] <= wdata;
                end
                analog_input_pkg::REG_FILT_K: begin
                    if (k_wr_ok) begin
                        k_reg[wch] <= wdata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end else if (wr_en && addr == analog_input_pkg::REG_CTRL) begin
            fast_reg <= wdata[analog_input_pkg::CTRL_FAST_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                ofs_reg[i] <= 16'sh0000;
            end
            aligned_reg <= '0;
        end else if (wr_en && ch_hit &&
            widx == analog_input_pkg::REG_ALIGN_OFS) begin
            ofs_reg[wch] <= clamp_s(40'($signed(wdata)),
                -analog_input_pkg::ALIGN_LIMIT, analog_input_pkg::ALIGN_LIMIT);
            aligned_reg[wch] <= wdata != 16'h0000;
        end else if (wr_en && ch_hit &&
            widx == analog_input_pkg::REG_ALIGN_TGT) begin
            ofs_reg[wch] <= clamp_s(40'($signed(wdata)) -
                40'(last_raw_reg[wch]),
                -analog_input_pkg::ALIGN_LIMIT, analog_input_pkg::ALIGN_LIMIT);
            aligned_reg[wch] <= 1'b1;
        end
    end

    // filter reload; a set in the sample cycle wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prime_reg <= '1;
        end else begin
            for (int i = 0; i < N; i++) begin
                if ((rng_change || k_wr_ok) && wch == i[1:0]) begin
                    prime_reg[i] <= 1'b1;
                end else if (samp_valid && samp_chan == i[1:0]) begin
                    prime_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Sample results.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                filt_reg[i] <= 24'sh000000;
                value_reg[i] <= 16'sh0000;
                corr_reg[i] <= 16'sh0000;
                last_raw_reg[i] <= 16'sh0000;
                status_reg[i] <= 5'h00;
            end
            valid_reg <= '0;
        end else if (samp_valid) begin
            filt_reg[samp_chan] <= filt_next;
            value_reg[samp_chan] <= scaled;
            corr_reg[samp_chan] <= corr;
            last_raw_reg[samp_chan] <= samp_raw;
            status_reg[samp_chan] <= {broken, hi_tol, lo_tol, ovf, udf};
            valid_reg[samp_chan] <= 1'b1;
        end
    end

    // Acquisition sequencer: slot 0 is overhead, slots 1..4 channels.
    logic skip;
    logic slot_end;
    logic cyc_start;

    always_comb begin
        // unused channels skipped in fast mode
        skip = fast_reg && slot_reg != 3'h0 &&
            !in_use_reg[2'(slot_reg - 3'h1)];
        slot_end = skip || tmr_reg == 18'(SLOT_CYCLES - 1);
        cyc_start = slot_end &&
            slot_reg == 3'(analog_input_pkg::FIXED_SLOTS - 1);
        acq_req = slot_end && !skip && slot_reg != 3'h0;
        acq_chan = 2'(slot_reg - 3'h1);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_reg <= 3'h0;
            tmr_reg <= 18'h00000;
        end else if (slot_end) begin
            tmr_reg <= 18'h00000;
            slot_reg <= cyc_start ? 3'h0 : slot_reg + 3'h1;
        end else begin
            tmr_reg <= tmr_reg + 18'h00001;
        end
    end

    // Read port.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (rd_en && ch_hit) begin
            case (widx)
                analog_input_pkg::REG_CFG:
                    rdata <= {11'h000, user_reg[wch], in_use_reg[wch],
                        range_reg[wch]};
                analog_input_pkg::REG_LO_THR: rdata <= lo_thr_reg[wch];
                analog_input_pkg::REG_HI_THR: rdata <= hi_thr_reg[wch];
                analog_input_pkg::REG_USER_LO: rdata <= user_lo_reg[wch];
                analog_input_pkg::REG_USER_HI: rdata <= user_hi_reg[wch];
                analog_input_pkg::REG_FILT_K: rdata <= {13'h0000, k_reg[wch]};
                analog_input_pkg::REG_ALIGN_OFS: rdata <= ofs_reg[wch];
                analog_input_pkg::REG_ALIGN_TGT: rdata <= corr_reg[wch];
                analog_input_pkg::REG_VALUE: rdata <= value_reg[wch];
                analog_input_pkg::REG_STATUS:
                    rdata <= {9'h000, valid_reg[wch], aligned_reg[wch],
                        status_reg[wch]};
                default: rdata <= 16'h0000;
            endcase
        end else if (rd_en && addr == analog_input_pkg::REG_CTRL) begin
            rdata <= {15'h0000, fast_reg};
        end else begin
            rdata <= 16'h0000;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_status
            assign over_range[g] = status_reg[g][analog_input_pkg::ST_OVF];
            assign under_range[g] = status_reg[g][analog_input_pkg::ST_UDF];
            assign broken_wire[g] = status_reg[g][analog_input_pkg::ST_BROKEN];
        end
    endgenerate

    // Cycle length watch for fixed mode.
    logic [19:0] gap_cnt;
    logic gap_ok;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt <= 20'h00000;
            gap_ok <= 1'b0;
        end else begin
            gap_cnt <= cyc_start ? 20'h00000 : gap_cnt + 20'h00001;
            if (wr_en && addr == analog_input_pkg::REG_CTRL) begin
                gap_ok <= 1'b0;
            end else if (cyc_start) begin
                gap_ok <= 1'b1;
            end
        end
    end

    overflow_flag_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        samp_valid && corr > hi_thr_reg[samp_chan]
        |=> status_reg[$past(samp_chan)][analog_input_pkg::ST_OVF])
        else $error("overflow not flagged");
    underflow_flag_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        samp_valid && corr < lo_thr_reg[samp_chan]
        |=> status_reg[$past(samp_chan)][analog_input_pkg::ST_UDF])
        else $error("underflow not flagged");
    tolerance_zone_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        samp_valid && corr > analog_input_pkg::NOM_MAX[srng] &&
        corr <= hi_thr_reg[samp_chan]
        |=> !status_reg[$past(samp_chan)][analog_input_pkg::ST_OVF] &&
        status_reg[$past(samp_chan)][analog_input_pkg::ST_HI_TOL])
        else $error("tolerance zone misclassified");
    threshold_indep_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        wr_en && ch_hit && widx == analog_input_pkg::REG_LO_THR
        |=> hi_thr_reg[$past(wch)] == $past(hi_thr_reg[wch]))
        else $error("upper threshold disturbed");
    bad_k_ignored_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        wr_en && ch_hit && widx == analog_input_pkg::REG_FILT_K &&
        wdata > 16'(analog_input_pkg::K_MAX)
        |=> k_reg[$past(wch)] == $past(k_reg[wch]))
        else $error("invalid filter setting taken");
    offset_limit_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        wr_en && ch_hit && widx == analog_input_pkg::REG_ALIGN_OFS
        |=> ofs_reg[$past(wch)] <= analog_input_pkg::ALIGN_LIMIT &&
        ofs_reg[$past(wch)] >= -analog_input_pkg::ALIGN_LIMIT)
        else $error("alignment offset out of limit");
    prime_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        samp_valid && prime_reg[samp_chan]
        |=> filt_reg[$past(samp_chan)] == {$past(corr), 8'h00})
        else $error("filter not reloaded");
    fixed_cycle_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        cyc_start && gap_ok && !fast_reg
        |-> gap_cnt == 20'(analog_input_pkg::FIXED_SLOTS * SLOT_CYCLES - 1))
        else $error("fixed cycle length wrong");

endmodule

// *** converter_model.sv ***
`timescale 1ns/1ns
module converter_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Request and levels.
    input wire logic acq_req,
    input wire logic [1:0] acq_chan,
    input wire logic [63:0] lvl,
    // Sample.
    output logic samp_valid,
    output logic [1:0] samp_chan,
    output logic signed [15:0] samp_raw
);
    // Between samples the data lines toggle so no stale value passes.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            samp_valid <= 1'b0;
            samp_chan <= 2'h0;
            samp_raw <= 16'h0000;
        end else if (acq_req) begin
            samp_valid <= 1'b1;
            samp_chan <= acq_chan;
            samp_raw <= lvl[acq_chan*16 +: 16];
        end else begin
            samp_valid <= 1'b0;
            samp_raw <= ~samp_raw;
        end
    end
endmodule

// *** analog_input_conditioning_tb.sv ***
`timescale 1ns/1ns
module analog_input_conditioning_tb;
    logic clock = 0, rst_n = 0, wr_en = 0, rd_en = 0, rd_q = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata;
    logic acq_req, samp_valid;
    logic [1:0] acq_chan, samp_chan;
    logic signed [15:0] samp_raw;
    logic [3:0] over_range, under_range, broken_wire;
    logic [63:0] lvl = 64'h0;
    logic [15:0] exp_q[$];
    logic [15:0] kv;
    int n;
    integer seed = 32'h4CC8, err_total = 0, num_checks = 0, i;
    analog_input_conditioning #(.SLOT_CYCLES(20)) dut_u (.clock(clock),
        .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .acq_req(acq_req),
        .acq_chan(acq_chan), .samp_valid(samp_valid),
        .samp_chan(samp_chan), .samp_raw(samp_raw),
        .over_range(over_range), .under_range(under_range),
        .broken_wire(broken_wire));
    converter_model conv_u (.clock(clock), .rst_n(rst_n),
        .acq_req(acq_req), .acq_chan(acq_chan), .lvl(lvl),
        .samp_valid(samp_valid), .samp_chan(samp_chan),
        .samp_raw(samp_raw));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [3:0] idx);
        return {2'b00, ch[1:0], idx};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        rd_en <= 1'b0;
    endtask
    // Waits for a request, or for a sample of one channel.
    task automatic wait_ev(input logic acq, input logic [1:0] ch,
            output int cnt);
        cnt = 0;
        do begin
            @(posedge clock);
            cnt++;
            if (cnt > 600) begin
                err_total++;
                final_report();
            end
        end while (!(acq ? acq_req === 1'b1 :
            samp_valid === 1'b1 && samp_chan === ch));
    endtask
    // Compares each read answer with the oldest expected note.
    always @(posedge clock) begin
        rd_q <= rd_en;
        if (rd_q) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rd(ra(0, analog_input_pkg::REG_LO_THR), 16'hD508);
        rd(ra(0, analog_input_pkg::REG_USER_HI), 16'h2710);
        wr(ra(0, analog_input_pkg::REG_HI_THR), 16'h7FFF);
        rd(ra(0, analog_input_pkg::REG_HI_THR), 16'h2C88);
        rd(ra(0, analog_input_pkg::REG_LO_THR), 16'hD508);
        for (i = 0; i < 4; i++) begin
            kv = 16'({$random(seed)} % 7);
            wr(ra(0, analog_input_pkg::REG_FILT_K), kv);
            rd(ra(0, analog_input_pkg::REG_FILT_K), kv);
        end
        wr(ra(0, analog_input_pkg::REG_FILT_K), 16'h0007);
        rd(ra(0, analog_input_pkg::REG_FILT_K), kv);
        wr(ra(0, analog_input_pkg::REG_ALIGN_OFS), 16'h07D0);
        rd(ra(0, analog_input_pkg::REG_ALIGN_OFS), 16'h05DC);
        wr(ra(3, analog_input_pkg::REG_CFG), 16'h000D);
        rd(ra(3, analog_input_pkg::REG_LO_THR), 16'hFCE0);
        rd(8'h3F, 16'h0000);
        lvl <= {16'hF448, 16'hD120, 16'h2EE0, 16'h0000};
        i = 0;
        while (!(over_range[1] === 1'b1 && broken_wire[3] === 1'b1)) begin
            @(posedge clock);
            i++;
            if (i > 600) begin
                err_total++;
                final_report();
            end
        end
        @(negedge clock);
        chk({12'h000, over_range}, 16'h0002);
        chk({12'h000, under_range}, 16'h000C);
        chk({12'h000, broken_wire}, 16'h0008);
        wr(ra(0, analog_input_pkg::REG_LO_THR), 16'h0064);
        rd(ra(0, analog_input_pkg::REG_LO_THR), 16'hD8F0);
        rd(ra(0, analog_input_pkg::REG_HI_THR), 16'h2C88);
        rd(ra(1, analog_input_pkg::REG_VALUE), 16'h2C88);
        rd(ra(1, analog_input_pkg::REG_STATUS), 16'h0042);
        wr(ra(2, analog_input_pkg::REG_CFG), 16'h0012);
        wr(ra(2, analog_input_pkg::REG_USER_LO), 16'h0C80);
        wr(ra(2, analog_input_pkg::REG_USER_HI), 16'h2580);
        wr(ra(1, analog_input_pkg::REG_FILT_K), 16'h0001);
        wait_ev(1'b0, 2'h1, n);
        lvl <= {16'hF448, 16'h1388, 16'h0000, 16'h29CC};
        wait_ev(1'b0, 2'h1, n);
        rd(ra(1, analog_input_pkg::REG_VALUE), 16'h2166);
        rd(ra(2, analog_input_pkg::REG_VALUE), 16'h1900);
        rd(ra(0, analog_input_pkg::REG_STATUS), 16'h0068);
        @(negedge clock);
        chk({8'h00, over_range, under_range}, 16'h0008);
        wr(ra(3, analog_input_pkg::REG_ALIGN_TGT), 16'hF830);
        rd(ra(3, analog_input_pkg::REG_ALIGN_OFS), 16'h03E8);
        rd(ra(3, analog_input_pkg::REG_STATUS), 16'h0071);
        wr(analog_input_pkg::REG_CTRL, 16'h0001);
        wait_ev(1'b1, 2'h0, n);
        chk({14'h0000, acq_chan}, 16'h0003);
        wait_ev(1'b1, 2'h0, n);
        chk(16'(n), 16'h002B);
        repeat (3) @(posedge clock);
        final_report();
    end
endmodule
